/* hdl/monitor_power_state_control_consts.vh */
// Purpose: constants for the monitor operating-state controller
// Assumes: 50 MHz ref_clk, APB register access, byte addresses
// Notes:   long counts feed parameter defaults of the top module
//
// Overview of operation
// - Sleep: reference and converters off, both ports idle, regulator drive off.
// - A wake-up while the core sleeps moves the core to standby.
// - Standby waits reference power-up on conversion or keep-on, then reference_ready_state, measure, or standby if neither is still asked.
// - Standby returns to sleep after sleep timeout once watchdog and discharge expire.
// - Reference-up is reached only after host writes keep-on to 1.
// - In reference-up a conversion command enters measure without power-up delay.
// - Keep-on cleared leaves reference-up to standby, or sleep if timers expired.
// - Finished conversions go to reference-up if keep-on, else standby.
// - Only conversion or diagnostic commands start measure; others still record the mode field outside measure and sleep.
// - Ports powered down while idle; a wake on either port leaves idle.
// - Idle to ready takes ready time in standby, wake time when asleep.
// - Ready with no port activity beyond idle timeout returns to idle.
// - Link goes active while data is being sent or received.
// - All-cell conversions run three converters; auxiliary inputs use one.
// - Conversion mode is option bit joined with two-bit command mode field.
// - Each conversion measures first, then calibrates each channel.
// - Eight modes give filter bandwidths from 27kHz down to 26Hz.
// - Keep-on holds the reference up so later conversions skip power-up.
// - No valid command for 2 s: watchdog expires, resets logic, releases pin.
`ifndef MONITOR_POWER_STATE_CONTROL_CONSTS_VH
`define MONITOR_POWER_STATE_CONTROL_CONSTS_VH

// ******************************
// register map
// ******************************
`define ADDR_CONFIG      12'h000
`define ADDR_COMMAND     12'h004
`define ADDR_STATUS      12'h008
`define ADDR_BANDWIDTH   12'h00c
`define CFG_OPTION_BIT   0
`define CFG_KEEP_ON_BIT  1
`define CMD_KIND_LSB     0
`define CMD_MODE_LSB     2

// ******************************
// command kinds
// ******************************
`define CMD_OTHER        2'h0
`define CMD_CONV_CELLS   2'h1
`define CMD_CONV_AUX     2'h2
`define CMD_DIAG         2'h3

// ******************************
// timing: times in their unit, rate in MHz
// ******************************
`define CLK_MHZ          50
`define WDT_TIME_MS      2000
`define REFERENCE_READY_STATE_TIME_US    4400
`define SLEEP_TIME_MS    1800
`define DISCH_TIME_MS    30000
`define IDLE_TIME_US     5500
`define READY_TIME_US    10
`define WAKE_TIME_US     400
`define MEAS_BASE_CYC    1000
`define CAL_CYC          2000

`endif

/* hdl/monitor_power_state_control.v */
// Purpose: operating-state control for a stackable cell monitor
// Assumes: async active-low reset; link pins are asynchronous
// Notes:   converter datapath is out of scope; only its phases are timed
`timescale 1ns/1ps
`default_nettype none
`include "monitor_power_state_control_consts.vh"

// timing counts are cycle parameters so a bench can shorten them
module monitor_power_state_control #(
  parameter [31:0] WDT_CYC   = `WDT_TIME_MS * `CLK_MHZ * 1000,
  parameter [31:0] REFERENCE_READY_STATE_CYC = `REFERENCE_READY_STATE_TIME_US * `CLK_MHZ,
  parameter [31:0] SLEEP_CYC = `SLEEP_TIME_MS * `CLK_MHZ * 1000,
  parameter [31:0] DISCH_CYC = `DISCH_TIME_MS * `CLK_MHZ * 1000,
  parameter [31:0] IDLE_CYC  = `IDLE_TIME_US * `CLK_MHZ,
  parameter [31:0] READY_CYC = `READY_TIME_US * `CLK_MHZ,
  parameter [31:0] WAKE_CYC  = `WAKE_TIME_US * `CLK_MHZ
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        resetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // link pins and discharge timer enable
  input  wire        port_a_wake,
  input  wire        port_b_wake,
  input  wire        link_sck,
  input  wire        discharge_timer_enable,
  // power controls
  output reg         reference_on,
  output reg  [2:0]  adc_enable,
  output reg         regulator_drive,
  output reg         port_a_power,
  output reg         port_b_power,
  // watchdog open-drain pin
  output reg         watchdog_output_o,
  output reg         watchdog_output_oe
);

  // ******************************
  // states
  // ******************************
  localparam [2:0] C_SLEEP = 3'h0;
  localparam [2:0] C_STBY  = 3'h1;
  localparam [2:0] C_PWRUP = 3'h2;
  localparam [2:0] C_REFERENCE_READY_STATE = 3'h3;
  localparam [2:0] C_MEAS  = 3'h4;
  localparam [1:0] L_IDLE  = 2'h0;
  localparam [1:0] L_WAKE  = 2'h1;
  localparam [1:0] L_READY = 2'h2;
  localparam [1:0] L_ACT   = 2'h3;

  reg  [2:0]  core_q;
  reg  [1:0]  link_q;
  reg         keep_on_q;
  reg         option_q;
  reg  [2:0]  mode_q;
  reg         aux_q;
  reg         pend_meas_q;
  reg         cal_q;
  reg  [31:0] core_cnt_q;
  reg  [31:0] link_cnt_q;
  reg  [31:0] wdt_cnt_q;
  reg  [31:0] slp_cnt_q;
  reg  [31:0] dis_cnt_q;
  reg  [2:0]  sck_hist_q;
  reg  [1:0]  wa_sync_q;
  reg  [1:0]  wb_sync_q;
  reg  [1:0]  dte_sync_q;

  // ******************************
  // input synchronisers
  // ******************************
  // second stage only is read; sck keeps a third stage for edge finding
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wa_sync_q  <= 2'h0;
      wb_sync_q  <= 2'h0;
      dte_sync_q <= 2'h0;
      sck_hist_q <= 3'h0;
    end else begin
      wa_sync_q  <= {wa_sync_q[0], port_a_wake};
      wb_sync_q  <= {wb_sync_q[0], port_b_wake};
      dte_sync_q <= {dte_sync_q[0], discharge_timer_enable};
      sck_hist_q <= {sck_hist_q[1:0], link_sck};
    end
  end

  wire wake_any = wa_sync_q[1] | wb_sync_q[1];
  wire sck_edge = sck_hist_q[2] ^ sck_hist_q[1];
  wire dte      = dte_sync_q[1];

  // ******************************
  // apb decode
  // ******************************
  // one wait state: pready is high in the second access cycle
  wire apb_acc  = psel & penable;
  wire apb_done = apb_acc & pready;
  wire wr       = apb_done & pwrite;
  wire wr_cfg   = wr & (paddr == `ADDR_CONFIG);
  wire wr_cmd   = wr & (paddr == `ADDR_COMMAND);
  wire [1:0] cmd_kind = pwdata[`CMD_KIND_LSB +: 2];
  // config and command writes are valid commands and kick the watchdog and sleep timers
  wire valid_cmd = wr_cfg | wr_cmd;
  wire conv_cmd  = wr_cmd & (cmd_kind != `CMD_OTHER);

  wire wdt_exp  = (wdt_cnt_q == 32'h0);
  wire dis_exp  = ~dte | (dis_cnt_q == 32'h0);
  wire slp_exp  = (slp_cnt_q == 32'h0);
  wire timers_out = wdt_exp & dis_exp;

  // bandwidth per mode index, in hertz
  function [31:0] bw_hz;
    input [2:0] m;
    begin
      case (m)
        3'h0:    bw_hz = 32'd27000;
        3'h1:    bw_hz = 32'd13500;
        3'h2:    bw_hz = 32'd6800;
        3'h3:    bw_hz = 32'd3400;
        3'h4:    bw_hz = 32'd1700;
        3'h5:    bw_hz = 32'd845;
        3'h6:    bw_hz = 32'd422;
        default: bw_hz = 32'd26;
      endcase
    end
  endfunction

  reg [31:0] rd_d;
  reg        err_d;
  // read mux; unmapped addresses answer with an error
  always @* begin
    rd_d  = 32'h0;
    err_d = 1'b0;
    if (paddr == `ADDR_CONFIG) begin
      rd_d[`CFG_OPTION_BIT]  = option_q;
      rd_d[`CFG_KEEP_ON_BIT] = keep_on_q;
    end else if (paddr == `ADDR_COMMAND) begin
      rd_d = {27'h0, mode_q[1:0], 1'b0, aux_q};
    end else if (paddr == `ADDR_STATUS) begin
      rd_d = {21'h0, dis_exp, wdt_exp, adc_enable, link_q, core_q};
    end else if (paddr == `ADDR_BANDWIDTH) begin
      rd_d = bw_hz(mode_q);
    end else begin
      err_d = 1'b1;
    end
  end

  // apb answer registers
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & err_d;
      if (apb_acc & ~pready) begin
        prdata <= pwrite ? 32'h0 : rd_d;
      end
    end
  end

  // ******************************
  // configuration and timers
  // ******************************
  // watchdog expiry clears configuration, as a logic reset would
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      keep_on_q <= 1'b0;
      option_q  <= 1'b0;
      wdt_cnt_q <= 32'h0;
      slp_cnt_q <= 32'h0;
      dis_cnt_q <= 32'h0;
    end else begin
      if (wr_cfg) begin
        keep_on_q <= pwdata[`CFG_KEEP_ON_BIT];
        option_q  <= pwdata[`CFG_OPTION_BIT];
      end else if (wdt_exp) begin
        keep_on_q <= 1'b0;
        option_q  <= 1'b0;
      end
      if (valid_cmd | (core_q == C_SLEEP & wake_any)) begin
        wdt_cnt_q <= WDT_CYC;
        slp_cnt_q <= SLEEP_CYC;
      end else begin
        if (!wdt_exp) wdt_cnt_q <= wdt_cnt_q - 32'h1;
        if (!slp_exp) slp_cnt_q <= slp_cnt_q - 32'h1;
      end
      // discharge timer restarts on each configuration write
      if (wr_cfg) begin
        dis_cnt_q <= DISCH_CYC;
      end else if (dis_cnt_q != 32'h0) begin
        dis_cnt_q <= dis_cnt_q - 32'h1;
      end
    end
  end

  // ******************************
  // core state machine
  // ******************************
  // measure length doubles per mode index; calibration is fixed
  wire [31:0] meas_len = (`MEAS_BASE_CYC << mode_q);
  wire [2:0]  cmd_mode = {option_q, pwdata[`CMD_MODE_LSB +: 2]};

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      core_q      <= C_SLEEP;
      core_cnt_q  <= 32'h0;
      pend_meas_q <= 1'b0;
      cal_q       <= 1'b0;
      mode_q      <= 3'h0;
      aux_q       <= 1'b0;
    end else begin
      // mode field is recorded from any command outside measure and sleep;
      // the running count is already loaded, so a late command cannot stretch it
      if (wr_cmd & core_q != C_MEAS & core_q != C_SLEEP) begin
        mode_q <= cmd_mode;
      end
      if (conv_cmd & core_q != C_MEAS & core_q != C_SLEEP) begin
        aux_q  <= (cmd_kind == `CMD_CONV_AUX);
      end
      case (core_q)
        C_SLEEP: begin
          if (wake_any) core_q <= C_STBY;
        end
        C_STBY: begin
          if (conv_cmd | keep_on_q) begin
            core_q      <= C_PWRUP;
            pend_meas_q <= conv_cmd;
            core_cnt_q  <= REFERENCE_READY_STATE_CYC;
          end else if (slp_exp & timers_out) begin
            core_q <= C_SLEEP;
          end
        end
        C_PWRUP: begin
          if (conv_cmd) pend_meas_q <= 1'b1;
          if (core_cnt_q > 32'h1) begin
            core_cnt_q <= core_cnt_q - 32'h1;
          end else if (pend_meas_q | conv_cmd) begin
            core_q     <= C_MEAS;
            cal_q      <= 1'b0;
            core_cnt_q <= meas_len;
          end else if (keep_on_q) begin
            core_q <= C_REFERENCE_READY_STATE;
          end else begin
            core_q <= C_STBY;
          end
        end
        C_REFERENCE_READY_STATE: begin
          if (conv_cmd) begin
            core_q     <= C_MEAS;
            cal_q      <= 1'b0;
            core_cnt_q <= (`MEAS_BASE_CYC << cmd_mode);
          end else if (!keep_on_q) begin
            core_q <= timers_out ? C_SLEEP : C_STBY;
          end
        end
        C_MEAS: begin
          if (core_cnt_q > 32'h1) begin
            core_cnt_q <= core_cnt_q - 32'h1;
          end else if (!cal_q) begin
            cal_q      <= 1'b1;
            core_cnt_q <= `CAL_CYC;
          end else begin
            core_q <= keep_on_q ? C_REFERENCE_READY_STATE : C_STBY;
          end
        end
        default: core_q <= C_SLEEP;
      endcase
    end
  end

  // ******************************
  // link state machine
  // ******************************
  // wake or clock edges count as activity and hold off the idle timeout
  wire link_act = wake_any | sck_edge;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link_q     <= L_IDLE;
      link_cnt_q <= 32'h0;
    end else begin
      case (link_q)
        L_IDLE: begin
          if (wake_any) begin
            link_q     <= L_WAKE;
            link_cnt_q <= (core_q == C_SLEEP) ? WAKE_CYC : READY_CYC;
          end
        end
        L_WAKE: begin
          if (link_cnt_q > 32'h1) begin
            link_cnt_q <= link_cnt_q - 32'h1;
          end else begin
            link_q     <= L_READY;
            link_cnt_q <= IDLE_CYC;
          end
        end
        L_READY: begin
          if (sck_edge) begin
            link_q     <= L_ACT;
            link_cnt_q <= IDLE_CYC;
          end else if (wake_any) begin
            link_cnt_q <= IDLE_CYC;
          end else if (link_cnt_q > 32'h1) begin
            link_cnt_q <= link_cnt_q - 32'h1;
          end else begin
            link_q <= L_IDLE;
          end
        end
        L_ACT: begin
          // a quiet stretch of the idle time ends the transfer
          if (link_act) begin
            link_cnt_q <= IDLE_CYC;
          end else if (link_cnt_q > 32'h1) begin
            link_cnt_q <= link_cnt_q - 32'h1;
          end else begin
            link_q     <= L_READY;
            link_cnt_q <= IDLE_CYC;
          end
        end
        default: link_q <= L_IDLE;
      endcase
      // a sleeping core keeps the ports idle until a wake arrives
      if (core_q == C_SLEEP & ~wake_any & link_q != L_WAKE) begin
        link_q <= L_IDLE;
      end
    end
  end

  // ******************************
  // registered power outputs
  // ******************************
  wire meas_nxt = (core_q == C_MEAS);
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reference_on       <= 1'b0;
      adc_enable         <= 3'h0;
      regulator_drive    <= 1'b0;
      port_a_power       <= 1'b0;
      port_b_power       <= 1'b0;
      watchdog_output_o  <= 1'b0;
      watchdog_output_oe <= 1'b0;
    end else begin
      reference_on    <= (core_q == C_PWRUP) | (core_q == C_REFERENCE_READY_STATE) | meas_nxt;
      adc_enable      <= !meas_nxt ? 3'h0 : (aux_q ? 3'h1 : 3'h7);
      regulator_drive <= (core_q != C_SLEEP);
      port_a_power    <= (link_q != L_IDLE);
      port_b_power    <= (link_q != L_IDLE);
      watchdog_output_o  <= 1'b0;
      watchdog_output_oe <= ~wdt_exp;
    end
  end

endmodule // monitor_power_state_control
`default_nettype wire

/* verif/link_partner.sv */
// Purpose: link-side neighbour giving wake-up pulses and clocked frames
// Assumes: link clock period 160 ns, clock still between frames
// Notes:   phase offset keeps link edges away from ref_clk edges
`timescale 1ns/1ps
`default_nettype none

module link_partner (
  // link pins seen by the block
  output logic port_a_wake,
  output logic port_b_wake,
  output logic link_sck
);
  // quiet link at start
  initial begin
    port_a_wake = 1'b0;
    port_b_wake = 1'b0;
    link_sck    = 1'b0;
  end

  // one wake-up pulse on the chosen port
  task automatic wake(input logic on_b);
    #7;
    if (on_b) port_b_wake = 1'b1;
    else port_a_wake = 1'b1;
    #100;
    port_a_wake = 1'b0;
    port_b_wake = 1'b0;
  endtask

  // frame of n link clocks; clock parks low after it
  task automatic frame(input int n);
    #7;
    repeat (n) begin
      #80 link_sck = 1'b1;
      #80 link_sck = 1'b0;
    end
  endtask
endmodule // link_partner
`default_nettype wire

/* verif/monitor_power_state_control_chk.sv */
// Purpose: temporal checks on the state controller pins
// Assumes: parameters handed on from the instance under test
// Notes:   state fields are checked by the bench over apb
`timescale 1ns/1ps
`default_nettype none

module monitor_power_state_control_chk #(
  parameter [31:0] WDT_CYC   = 32'h7d0,
  parameter [31:0] REFERENCE_READY_STATE_CYC = 32'h14,
  parameter [31:0] IDLE_CYC  = 32'hc8
) (
  // clock, reset, apb
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // link pins
  input wire logic        port_a_wake,
  input wire logic        port_b_wake,
  input wire logic        link_sck,
  // power and watchdog
  input wire logic        reference_on,
  input wire logic [2:0]  adc_enable,
  input wire logic        regulator_drive,
  input wire logic        port_a_power,
  input wire logic        watchdog_output_o,
  input wire logic        watchdog_output_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [31:0] cmd_age_q;
  logic [31:0] conv_age_q;
  logic [31:0] quiet_q;
  logic        sck_q;
  wire cmd_w  = psel && penable && pready && pwrite && paddr[11:3] == 9'h0;
  wire conv_w = cmd_w && paddr[2] && pwdata[1:0] != 2'h0;
  wire act_w  = port_a_wake || port_b_wake || link_sck != sck_q;
  // ages saturate so long idle spans never wrap to small values
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_age_q  <= 32'h0;
      conv_age_q <= 32'hffff;
      quiet_q    <= 32'h0;
      sck_q      <= 1'b0;
    end else begin
      cmd_age_q  <= cmd_w ? 32'h0 : cmd_age_q + {31'h0, ~&cmd_age_q};
      conv_age_q <= conv_w ? 32'h0 : conv_age_q + {31'h0, ~&conv_age_q};
      quiet_q    <= act_w ? 32'h0 : quiet_q + {31'h0, ~&quiet_q};
      sck_q      <= link_sck;
    end
  end

  property p_sleep_dark;
    !regulator_drive |-> !reference_on && adc_enable == 3'h0;
  endproperty
  a_sleep_dark: assert property (p_sleep_dark) else $error("power on while asleep");
  property p_wake_up;
    $rose(port_a_wake) && !regulator_drive |-> ##[3:6] regulator_drive;
  endproperty
  a_wake_up: assert property (p_wake_up) else $error("wake did not start core");
  property p_adc_codes;
    adc_enable == 3'h0 || adc_enable == 3'h1 || adc_enable == 3'h7;
  endproperty
  a_adc_codes: assert property (p_adc_codes) else $error("bad converter set");
  property p_adc_ref;
    adc_enable != 3'h0 |-> reference_on;
  endproperty
  a_adc_ref: assert property (p_adc_ref) else $error("convert without reference");
  property p_conv_cause;
    $rose(adc_enable != 3'h0) |-> conv_age_q <= REFERENCE_READY_STATE_CYC + 32'h8;
  endproperty
  a_conv_cause: assert property (p_conv_cause) else $error("measure without command");
  property p_link_quiet;
    $fell(port_a_power) |-> quiet_q >= IDLE_CYC;
  endproperty
  a_link_quiet: assert property (p_link_quiet) else $error("link idled too soon");
  property p_wdt_quiet;
    $fell(watchdog_output_oe) |-> cmd_age_q >= WDT_CYC - 32'h2;
  endproperty
  a_wdt_quiet: assert property (p_wdt_quiet) else $error("watchdog expired early");
  property p_open_drain;
    watchdog_output_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("watchdog pin driven high");
endmodule // monitor_power_state_control_chk

bind monitor_power_state_control monitor_power_state_control_chk #(.WDT_CYC(WDT_CYC),
  .REFERENCE_READY_STATE_CYC(REFERENCE_READY_STATE_CYC), .IDLE_CYC(IDLE_CYC)) chk_i (.ref_clk, .resetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .port_a_wake, .port_b_wake, .link_sck,
  .reference_on, .adc_enable, .regulator_drive, .port_a_power, .watchdog_output_o,
  .watchdog_output_oe);
`default_nettype wire

/* verif/test_monitor_power_state_control.sv */
// Purpose: self-checking bench for the monitor state controller
// Assumes: shortened timing parameters; state polled over apb
// Notes:   link traffic comes from the partner model
`timescale 1ns/1ps
`default_nettype none
`include "monitor_power_state_control_consts.vh"

module test_monitor_power_state_control;
  logic        ref_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        port_a_wake, port_b_wake, link_sck, discharge_timer_enable;
  logic        reference_on, regulator_drive, port_a_power, port_b_power;
  logic [2:0]  adc_enable;
  logic        watchdog_output_o, watchdog_output_oe;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  logic [31:0] bw [8] = '{32'h6978, 32'h34bc, 32'h1a90, 32'hd48, 32'h6a4, 32'h34d,
                          32'h1a6, 32'h1a};

  // shortened timing, so each timeout is reached within the run
  localparam logic [31:0] T_WDT   = 32'd2000;
  localparam logic [31:0] REFERENCE_POWERUP_TIME = 32'd20;
  localparam logic [31:0] T_SLEEP = 32'd1000;
  localparam logic [31:0] T_DISCH = 32'd3000;
  localparam logic [31:0] T_IDLE  = 32'd200;
  localparam logic [31:0] T_READY = 32'd5;
  localparam logic [31:0] T_WAKE  = 32'd40;

  monitor_power_state_control #(.WDT_CYC(T_WDT), .REFERENCE_READY_STATE_CYC(REFERENCE_POWERUP_TIME), .SLEEP_CYC(T_SLEEP),
    .DISCH_CYC(T_DISCH), .IDLE_CYC(T_IDLE), .READY_CYC(T_READY), .WAKE_CYC(T_WAKE)) dut (.ref_clk,
    .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .port_a_wake, .port_b_wake, .link_sck, .discharge_timer_enable, .reference_on,
    .adc_enable, .regulator_drive, .port_a_power, .port_b_power, .watchdog_output_o,
    .watchdog_output_oe);
  link_partner part (.port_a_wake, .port_b_wake, .link_sck);

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  // one apb transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic core(input logic [2:0] c);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk("core state", rd[2:0], c);
  endtask
  task automatic link(input logic [1:0] l);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk("link state", rd[4:3], l);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // hang guard, well beyond the expected run
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    discharge_timer_enable = 1'b0;
    wt(5);
    resetn <= 1'b1;
    chk("drive", regulator_drive, 1'b0);
    core(3'h0);
    link(2'h0);
    chk("port a power", port_a_power, 1'b0);
    part.wake(1'b0);
    wt(20);
    core(3'h1);
    link(2'h1);
    wt(30);
    link(2'h2);
    wt(260);
    link(2'h0);
    part.wake(1'b1);
    wt(10);
    link(2'h2);
    chk("port b power", port_b_power, 1'b1);
    fork
      part.frame(16);
      begin
        wt(40);
        link(2'h3);
      end
    join
    wt(230);
    link(2'h2);
    // cells conversion from standby, idle command mid-measure
    apb(1'b1, `ADDR_COMMAND, 32'h1);
    core(3'h2);
    wt(30);
    core(3'h4);
    chk("adc", adc_enable, 3'h7);
    wt(1400);
    apb(1'b1, `ADDR_COMMAND, 32'h0);
    core(3'h4);
    wt(1500);
    core(3'h4);
    wt(100);
    core(3'h1);
    // keep-on path: reference stays up, aux conversion starts at once
    apb(1'b1, `ADDR_CONFIG, 32'h2);
    wt(30);
    core(3'h3);
    apb(1'b1, `ADDR_COMMAND, 32'h2);
    core(3'h4);
    wt(1400);
    chk("adc", adc_enable, 3'h1);
    apb(1'b1, `ADDR_COMMAND, 32'h0);
    wt(1650);
    core(3'h3);
    chk("reference", reference_on, 1'b1);
    apb(1'b1, `ADDR_CONFIG, 32'h0);
    core(3'h1);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `ADDR_CONFIG, 32'(i / 4));
      apb(1'b1, `ADDR_COMMAND, 32'(i % 4) << 2);
      apb(1'b0, `ADDR_BANDWIDTH, 32'h0);
      chk("bandwidth", rd, bw[i]);
      core(3'h1);
    end
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", err, 1'b1);
    wt(1900);
    core(3'h1);
    chk("wdt enable", watchdog_output_oe, 1'b1);
    wt(200);
    core(3'h0);
    chk("wdt enable", watchdog_output_oe, 1'b0);
    part.wake(1'b0);
    wt(10);
    apb(1'b1, `ADDR_CONFIG, 32'h2);
    wt(2100);
    core(3'h0);
    discharge_timer_enable <= 1'b1;
    part.wake(1'b1);
    wt(10);
    apb(1'b1, `ADDR_CONFIG, 32'h0);
    wt(2100);
    core(3'h1);
    wt(1000);
    core(3'h0);
    give_verdict();
  end
endmodule // test_monitor_power_state_control
`default_nettype wire
